// [inc/bay_defs.svh]
`ifndef BAY_DEFS_SVH
`define BAY_DEFS_SVH

`define BAY_NUM 2
`define BAY_CLK_MHZ 100
`define BAY_DEBOUNCE_MS 64
`define BAY_SETTLE_MS 100
`define BAY_DEBOUNCE_CYC (`BAY_DEBOUNCE_MS * 1000 * `BAY_CLK_MHZ)
`define BAY_SETTLE_CYC (`BAY_SETTLE_MS * 1000 * `BAY_CLK_MHZ)

`define BAY_OFF_IRQ_STAT 12'h000
`define BAY_OFF_IRQ_MASK 12'h004
`define BAY_OFF_BAY_BASE 12'h010
`define BAY_BAY_STRIDE 12'h008
`define BAY_OFF_CTRL_BIT 2

`define BAY_ST_CHANGE 0
`define BAY_ST_REMOVE 1
`define BAY_ST_PRESENT 2
`define BAY_ST_SERIAL 3
`define BAY_ST_FIREWIRE 4
`define BAY_ST_BUTTON 5
`define BAY_ST_SETTLING 6

`define BAY_CT_CHANGE_EN 0
`define BAY_CT_REMOVE_EN 1
`define BAY_CT_POWER 2
`define BAY_CT_SAFE 3

`define BAY_CTRL_RST 1'b0
`define BAY_MASK_RST 1'b0

`endif

// [inc/bay_pkg.sv]
package bay_pkg;
  typedef enum logic {SETTLE_IDLE, SETTLE_RUN} settle_e;
  typedef enum logic [2:0] {REG_NONE, REG_IRQ_STAT, REG_IRQ_MASK, REG_BAY_STAT, REG_BAY_CTRL} reg_kind_e;
endpackage

// [logic/bay_debounce.sv]
`timescale 1ns/100ps
module bay_debounce #(
  parameter int unsigned CYCLES = 4,
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);
  logic s1_q, s2_q, lvl_q, lvl_d;
  logic [31:0] cnt_q, cnt_d;

  // new level accepted only after it has stood unchanged for CYCLES clocks
  always_comb begin
    lvl_d = lvl_q;
    cnt_d = 32'h0;
    if (s2_q != lvl_q) begin
      if (cnt_q + 32'h1 >= CYCLES) begin
        lvl_d = s2_q;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= IDLE_LEVEL;
      s2_q <= IDLE_LEVEL;
      lvl_q <= IDLE_LEVEL;
      cnt_q <= 32'h0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = lvl_q;
endmodule

// [logic/bay_event_controller.sv]
`timescale 1ns/100ps
`include "bay_defs.svh"
// What this block does
// - enable and control bits read back exactly what software last wrote.
// - plain status bits show the current signal level, no latching.
// - sticky flags set on their source event and then stay set.
// - bay sticky flags clear only by software writing one, zero leaves them; IRQ status bits clear on read.
// - falling presence edge, after 64 ms debounce, starts the settle timer.
// - settle timer expiry sets the bay's device-change flag.
// - each device-change flag has its own enable gating its event.
// - button press with device present sets the removal-request flag.
// - button debounced over 64 ms so one press gives one event.
// - removal-request flag has its own enable gating its event.
// - every bay has button input, removal flag and removal enable.
// - bay indicator shows whether removing the device is safe now.
// - power switch enable output follows the bay's power control bit.
module bay_event_controller
  import bay_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = `BAY_DEBOUNCE_CYC,
  parameter int unsigned SETTLE_CYCLES = `BAY_SETTLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [`BAY_NUM-1:0] serial_bus_presence_n,
  input wire logic [`BAY_NUM-1:0] firewire_presence_n,
  input wire logic [`BAY_NUM-1:0] removal_button_input,
  output logic [`BAY_NUM-1:0] power_switch_enable,
  output logic [`BAY_NUM-1:0] safe_to_remove,
  output logic bay_event,
  output logic irq
);
  localparam int NB = `BAY_NUM;

  function automatic reg_kind_e decode_kind(input logic [11:0] a);
    logic [11:0] off;
    off = a - `BAY_OFF_BAY_BASE;
    if (a == `BAY_OFF_IRQ_STAT) decode_kind = REG_IRQ_STAT;
    else if (a == `BAY_OFF_IRQ_MASK) decode_kind = REG_IRQ_MASK;
    else if (a >= `BAY_OFF_BAY_BASE && off < 12'(NB * 8) && a[1:0] == 2'b00)
      decode_kind = off[`BAY_OFF_CTRL_BIT] ? REG_BAY_CTRL : REG_BAY_STAT;
    else decode_kind = REG_NONE;
  endfunction

  function automatic int decode_bay(input logic [11:0] a);
    logic [11:0] off;
    off = a - `BAY_OFF_BAY_BASE;
    decode_bay = int'(off[11:3]);
  endfunction

  logic [NB-1:0] ser_db, fw_db, btn_db;

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_deb
      bay_debounce #(.CYCLES(DEBOUNCE_CYCLES), .IDLE_LEVEL(1'b1)) u_ser (
        .hclk(hclk), .hresetn(hresetn), .pin(serial_bus_presence_n[g]), .level(ser_db[g]));
      bay_debounce #(.CYCLES(DEBOUNCE_CYCLES), .IDLE_LEVEL(1'b1)) u_fw (
        .hclk(hclk), .hresetn(hresetn), .pin(firewire_presence_n[g]), .level(fw_db[g]));
      bay_debounce #(.CYCLES(DEBOUNCE_CYCLES), .IDLE_LEVEL(1'b0)) u_btn (
        .hclk(hclk), .hresetn(hresetn), .pin(removal_button_input[g]), .level(btn_db[g]));
    end
  endgenerate

  // bus state
  logic dph_q, dph_d, wr_q, wr_d;
  logic [11:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic accept;
  reg_kind_e kind;
  int bsel;

  // bay state
  logic [NB-1:0] chg_q, chg_d, rem_q, rem_d;
  logic [NB-1:0] chg_en_q, chg_en_d, rem_en_q, rem_en_d;
  logic [NB-1:0] pwr_q, pwr_d, safe_sw_q, safe_sw_d, safe_q, safe_d;
  logic [NB-1:0] pser_q, pser_d, pfw_q, pfw_d, pbtn_q, pbtn_d;
  settle_e st_q [NB], st_d [NB];
  logic [31:0] cnt_q [NB], cnt_d [NB];
  logic [NB-1:0] present, chg_set, rem_set, fall;
  logic [2*NB-1:0] ist_q, ist_d, imask_q, imask_d;
  logic ev_q, ev_d, irq_q, irq_d;

  assign accept = hsel && hready && htrans[1] && !dph_q;
  assign kind = decode_kind(addr_q);
  assign bsel = decode_bay(addr_q);

  always_comb begin
    dph_d = accept;
    wr_d = accept ? hwrite : wr_q;
    addr_d = accept ? haddr[11:0] : addr_q;
    rdata_d = rdata_q;
    chg_d = chg_q;
    rem_d = rem_q;
    chg_en_d = chg_en_q;
    rem_en_d = rem_en_q;
    pwr_d = pwr_q;
    safe_sw_d = safe_sw_q;
    safe_d = safe_q;
    pser_d = ser_db;
    pfw_d = fw_db;
    pbtn_d = btn_db;
    imask_d = imask_q;
    ist_d = ist_q;
    present = '0;
    chg_set = '0;
    rem_set = '0;
    fall = '0;
    for (int b = 0; b < NB; b++) begin
      st_d[b] = st_q[b];
      cnt_d[b] = cnt_q[b];
      present[b] = !ser_db[b] || !fw_db[b];
      fall[b] = (pser_q[b] && !ser_db[b]) || (pfw_q[b] && !fw_db[b]);
      unique case (st_q[b])
        SETTLE_IDLE: begin
          if (fall[b]) begin
            st_d[b] = SETTLE_RUN;
            cnt_d[b] = SETTLE_CYCLES - 32'h1;
          end
        end
        SETTLE_RUN: begin
          // a device pulled out mid-settle never reports insertion
          if (fall[b]) begin
            cnt_d[b] = SETTLE_CYCLES - 32'h1;
          end else if (!present[b]) begin
            st_d[b] = SETTLE_IDLE;
          end else if (cnt_q[b] == 32'h0) begin
            st_d[b] = SETTLE_IDLE;
            chg_set[b] = 1'b1;
          end else begin
            cnt_d[b] = cnt_q[b] - 32'h1;
          end
        end
      endcase
      rem_set[b] = btn_db[b] && !pbtn_q[b] && present[b];
      safe_d[b] = !present[b] || safe_sw_q[b];
    end
    // data phase: writes take hwdata now, reads sample; only an IRQ status read also clears
    if (dph_q) begin
      if (wr_q) begin
        unique case (kind)
          REG_IRQ_MASK: imask_d = hwdata[2*NB-1:0];
          REG_BAY_STAT: begin
            chg_d[bsel] = chg_q[bsel] && !hwdata[`BAY_ST_CHANGE];
            rem_d[bsel] = rem_q[bsel] && !hwdata[`BAY_ST_REMOVE];
          end
          REG_BAY_CTRL: begin
            chg_en_d[bsel] = hwdata[`BAY_CT_CHANGE_EN];
            rem_en_d[bsel] = hwdata[`BAY_CT_REMOVE_EN];
            pwr_d[bsel] = hwdata[`BAY_CT_POWER];
            safe_sw_d[bsel] = hwdata[`BAY_CT_SAFE];
          end
          default: ;
        endcase
      end else begin
        rdata_d = 32'h0;
        unique case (kind)
          REG_IRQ_STAT: begin
            rdata_d[2*NB-1:0] = ist_q;
            ist_d = '0;
          end
          REG_IRQ_MASK: rdata_d[2*NB-1:0] = imask_q;
          REG_BAY_STAT: begin
            rdata_d[`BAY_ST_CHANGE] = chg_q[bsel];
            rdata_d[`BAY_ST_REMOVE] = rem_q[bsel];
            rdata_d[`BAY_ST_PRESENT] = present[bsel];
            rdata_d[`BAY_ST_SERIAL] = !ser_db[bsel];
            rdata_d[`BAY_ST_FIREWIRE] = !fw_db[bsel];
            rdata_d[`BAY_ST_BUTTON] = btn_db[bsel];
            rdata_d[`BAY_ST_SETTLING] = (st_q[bsel] == SETTLE_RUN);
          end
          REG_BAY_CTRL: begin
            rdata_d[`BAY_CT_CHANGE_EN] = chg_en_q[bsel];
            rdata_d[`BAY_CT_REMOVE_EN] = rem_en_q[bsel];
            rdata_d[`BAY_CT_POWER] = pwr_q[bsel];
            rdata_d[`BAY_CT_SAFE] = safe_sw_q[bsel];
          end
          default: ;
        endcase
      end
    end
    // hardware set wins over any clear in the same cycle
    chg_d = chg_d | chg_set;
    rem_d = rem_d | rem_set;
    for (int b = 0; b < NB; b++) begin
      ist_d[2*b] = ist_d[2*b] | chg_set[b];
      ist_d[2*b+1] = ist_d[2*b+1] | rem_set[b];
    end
    ev_d = |((chg_q & chg_en_q) | (rem_q & rem_en_q));
    irq_d = |(ist_q & imask_q);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 12'h000;
      rdata_q <= 32'h0;
      chg_q <= '0;
      rem_q <= '0;
      chg_en_q <= {NB{`BAY_CTRL_RST}};
      rem_en_q <= {NB{`BAY_CTRL_RST}};
      pwr_q <= {NB{`BAY_CTRL_RST}};
      safe_sw_q <= {NB{`BAY_CTRL_RST}};
      safe_q <= '1;
      pser_q <= '1;
      pfw_q <= '1;
      pbtn_q <= '0;
      imask_q <= {2*NB{`BAY_MASK_RST}};
      ist_q <= '0;
      ev_q <= 1'b0;
      irq_q <= 1'b0;
      for (int b = 0; b < NB; b++) begin
        st_q[b] <= SETTLE_IDLE;
        cnt_q[b] <= 32'h0;
      end
    end else begin
      dph_q <= dph_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      chg_q <= chg_d;
      rem_q <= rem_d;
      chg_en_q <= chg_en_d;
      rem_en_q <= rem_en_d;
      pwr_q <= pwr_d;
      safe_sw_q <= safe_sw_d;
      safe_q <= safe_d;
      pser_q <= pser_d;
      pfw_q <= pfw_d;
      pbtn_q <= pbtn_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      ev_q <= ev_d;
      irq_q <= irq_d;
      for (int b = 0; b < NB; b++) begin
        st_q[b] <= st_d[b];
        cnt_q[b] <= cnt_d[b];
      end
    end
  end

  // one wait state keeps read-after-write ordering simple
  assign hreadyout = !dph_q;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign power_switch_enable = pwr_q;
  assign safe_to_remove = safe_q;
  assign bay_event = ev_q;
  assign irq = irq_q;

  logic wr_stat0, wr_ctrl0;
  assign wr_stat0 = dph_q && wr_q && kind == REG_BAY_STAT && bsel == 0;
  assign wr_ctrl0 = dph_q && wr_q && kind == REG_BAY_CTRL && bsel == 0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ctrl_readback;
    wr_ctrl0 |=> chg_en_q[0] == $past(hwdata[`BAY_CT_CHANGE_EN]) && rem_en_q[0] == $past(hwdata[`BAY_CT_REMOVE_EN]);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control bit not stored");

  property p_power_follows;
    wr_ctrl0 |=> power_switch_enable[0] == $past(hwdata[`BAY_CT_POWER]);
  endproperty
  a_power_follows: assert property (p_power_follows) else $error("power enable mismatch");

  property p_flag_sticky;
    chg_q[0] && !(wr_stat0 && hwdata[`BAY_ST_CHANGE]) |=> chg_q[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("change flag lost");

  property p_flag_w1c;
    wr_stat0 && hwdata[`BAY_ST_REMOVE] && !rem_set[0] |=> !rem_q[0];
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("removal flag not cleared");

  property p_flag_rise_cause;
    $rose(chg_q[0]) |-> $past(st_q[0] == SETTLE_RUN && cnt_q[0] == 32'h0 && present[0]);
  endproperty
  a_flag_rise_cause: assert property (p_flag_rise_cause) else $error("change flag set without expiry");

  property p_settle_start;
    fall[0] |=> st_q[0] == SETTLE_RUN && cnt_q[0] == SETTLE_CYCLES - 32'h1;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settle timer not started");

  property p_press_sets;
    btn_db[0] && !pbtn_q[0] && present[0] |=> rem_q[0] ##1 (!$past(rem_en_q[0]) || bay_event);
  endproperty
  a_press_sets: assert property (p_press_sets) else $error("press did not flag removal");

  property p_event_gate;
    ##1 bay_event == $past(|((chg_q & chg_en_q) | (rem_q & rem_en_q)));
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("event output wrong");

  property p_safe_empty;
    !present[0] |=> safe_to_remove[0];
  endproperty
  a_safe_empty: assert property (p_safe_empty) else $error("empty bay shown unsafe");

  property p_one_wait;
    accept |=> !hreadyout ##1 hreadyout;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait state wrong");

  c_insert: cover property ($rose(chg_q[0]));
  c_remove: cover property ($rose(rem_q[0]));
  c_irq: cover property ($rose(irq));
  c_clear: cover property (wr_stat0 ##1 !chg_q[0]);
endmodule

// [sim/bay_partner.sv]
`timescale 1ns/100ps
module bay_partner (
  input wire logic hclk,
  input wire logic [1:0] ser_in,
  input wire logic [1:0] fw_in,
  input wire logic [1:0] press,
  output logic [1:0] serial_bus_presence_n,
  output logic [1:0] firewire_presence_n,
  output logic [1:0] removal_button_input
);
  initial begin
    serial_bus_presence_n = 2'b11;
    firewire_presence_n = 2'b11;
    removal_button_input = 2'b00;
  end
  // presence pins pulled up, so an empty bay reads high
  always @(posedge hclk) begin
    serial_bus_presence_n <= ~ser_in;
    firewire_presence_n <= ~fw_in;
    removal_button_input <= press;
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam int DB = 4;
  localparam int ST = 8;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [31:0] hwdata = '0;
  logic hready, hreadyout, hresp, irq, bay_event;
  logic [31:0] hrdata, rv;
  logic [31:0] rnd = 32'hddab;
  logic [11:0] a;
  logic [1:0] ser = '0, fw = '0, press = '0, sp_n, fp_n, btn, pwr, safe;
  int fails = 0, num_checks = 0, cyc = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  bay_event_controller #(.DEBOUNCE_CYCLES(DB), .SETTLE_CYCLES(ST)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_bus_presence_n(sp_n),
    .firewire_presence_n(fp_n), .removal_button_input(btn), .power_switch_enable(pwr),
    .safe_to_remove(safe), .bay_event(bay_event), .irq(irq));
  bay_partner far (.hclk(hclk), .ser_in(ser), .fw_in(fw), .press(press), .serial_bus_presence_n(sp_n),
    .firewire_presence_n(fp_n), .removal_button_input(btn));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] stat(input logic c, r, s, f, b);
    return {25'h0, 1'b0, b, f, s, s | f, r, c};
  endfunction
  // called just after a rising edge; each phase held until hready is seen high at an edge
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, ad};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
    bus(0, ad, 32'h0);
    `CHK(rv, e)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    `CHK(safe, 2'b11)
    `CHK(pwr, 2'b00)
    rchk(12'h014, 32'h0);
    rchk(12'h01c, 32'h0);
    rchk(12'h004, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      a = i[0] ? 12'h01c : 12'h014;
      bus(1, a, rnd);
      rchk(a, {28'h0, rnd[3:0]});
      `CHK(pwr[i[0]], rnd[2])
    end
    bus(1, 12'h0f0, 32'hffffffff);
    rchk(12'h0f0, 32'h0);
    $display("test control done");
    bus(1, 12'h014, 32'h1);
    bus(1, 12'h01c, 32'h0);
    bus(1, 12'h004, 32'h1);
    ser[0] <= 1;
    wait_cyc(30);
    rchk(12'h010, stat(1, 0, 1, 0, 0));
    `CHK(bay_event, 1'b1)
    `CHK(irq, 1'b1)
    `CHK(safe[0], 1'b0)
    rchk(12'h000, 32'h1);
    wait_cyc(2);
    `CHK(irq, 1'b0)
    bus(1, 12'h014, 32'h8);
    wait_cyc(2);
    `CHK(bay_event, 1'b0)
    `CHK(safe[0], 1'b1)
    bus(1, 12'h010, 32'h0);
    rchk(12'h010, stat(1, 0, 1, 0, 0));
    bus(1, 12'h010, 32'h1);
    rchk(12'h010, stat(0, 0, 1, 0, 0));
    $display("test insertion done");
    // a one-cycle glitch before the steady press must not count
    bus(1, 12'h014, 32'h2);
    press[0] <= 1;
    @(posedge hclk);
    press[0] <= 0;
    @(posedge hclk);
    press[0] <= 1;
    wait_cyc(20);
    rchk(12'h010, stat(0, 1, 1, 0, 1));
    `CHK(bay_event, 1'b1)
    bus(1, 12'h010, 32'h2);
    wait_cyc(20);
    rchk(12'h010, stat(0, 0, 1, 0, 1));
    `CHK(bay_event, 1'b0)
    press[0] <= 0;
    press[1] <= 1;
    wait_cyc(20);
    rchk(12'h018, stat(0, 0, 0, 0, 1));
    press[1] <= 0;
    $display("test removal done");
    bus(1, 12'h01c, 32'h1);
    fw[1] <= 1;
    wait_cyc(10);
    rchk(12'h018, stat(0, 0, 0, 1, 0) | 32'h40);
    wait_cyc(30);
    rchk(12'h018, stat(1, 0, 0, 1, 0));
    `CHK(bay_event, 1'b1)
    fw[1] <= 0;
    wait_cyc(30);
    rchk(12'h018, stat(1, 0, 0, 0, 0));
    `CHK(safe[1], 1'b1)
    $display("test second bay done");
    wrap_up;
  end
endmodule
